// file: core/svof_formatter.sv
`timescale 1ns/100ps
`include "svof_params.svh"

// Behaviour
// [R1] bus words leave on the rising edge of core_clk
// [R2] pixels clipped to 1..1022 (10-bit) or 1..254 (8-bit)
// [R3] black level is 64 in 10-bit and 16 in 8-bit output
// [R4] 5-wire mode sends each 10-bit word as two 5-bit nibbles, high first
// [R5] 8-bit quantities in 10-bit mode get two zero low bits
// [R6] 8-wire mode sends one whole byte per clock
// [R7] 8-wire mode turns both strobe pins into data bits
// [R8] 4-wire mode sends each byte as two 4-bit nibbles, high first
// [R9] 8-bit pixels and averages use the top eight of ten bits
// [R10] narrow modes use the lowest data wires
// [R11] control sequences are interleaved with pixels on one bus
// [R12] timing references are field, line, end codes and a line count
// [R13] each control sequence is six bytes long
// [R14] command byte coded so single-bit errors can be corrected
// [R15] host drops sync on double-bit errors or two ends without start
// [R16] host drops sync on early end-of-field or non-sequential lines
// [R17] host discards the rest of the field after losing sync
// [R18] sequence opens with two all-ones words then an all-zero word
// [R19] the sync word is always followed directly by a command byte
// [R20] command byte is three code bits, four parity bits, one fixed one
// [R21] line-start tail carries 12-bit line number as two parity halves
// [R22] end-of-line tail is the middle-pixel average then all ones
// [R23] bus driven only while video output is enabled
// [R24] line count steps per line and restarts every field
module svof_formatter
  import svof_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       videoEn,
  input  wire svof_mode_t outMode,
  input  wire logic       quarterFmt,
  input  wire logic [9:0] lineWidth,
  input  wire logic       inValid,
  input  wire logic       inIsCtl,
  input  wire logic [9:0] inData,
  output logic            inReady,
  input  wire logic [5:0] videoDataIn,
  output logic      [5:0] videoDataOut,
  output logic            videoDataOe,
  output logic            fieldStartStrobe,
  output logic            lineStartStrobe
);

  localparam logic [9:0] ESC10  = {`SVOF_ESC_BYTE, 2'b00};
  localparam logic [9:0] SYNC10 = {`SVOF_SYNC_BYTE, 2'b00};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // input buffer
  // ****************************************
  logic        fValid;
  logic [10:0] fData;
  logic        fReady;

  svof_fifo #(
    .WIDTH (`SVOF_FIFO_WIDTH),
    .DEPTH (`SVOF_FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (inValid),
    .inData   ({inIsCtl, inData}),
    .inReady  (inReady),
    .outValid (fValid),
    .outData  (fData),
    .outReady (fReady)
  );

  // ****************************************
  // word sequencing state
  // ****************************************
  svof_seq_t   state_q;
  svof_seq_t   state_d;
  logic [9:0]  curWord_q;
  logic [9:0]  nextWord;
  logic        curValid_q;
  logic        nextValid;
  logic        curIsPix_q;
  logic        curIsCmd_q;
  logic        beat_q;
  logic        lastBeat;
  logic        advance;
  logic        popPix;
  logic        popCtl;
  logic        mode10;
  logic [2:0]  code_q;
  logic [11:0] lineCnt_q;
  logic        codeIsEol;
  logic        codeIsSof;
  logic        newIsEol;
  logic        newIsSof;
  logic [7:0]  cmdByte;
  logic [7:0]  numHiByte;
  logic [7:0]  numLoByte;

  assign mode10    = (outMode == SVOF_W5);
  assign lastBeat  = (outMode != SVOF_W8);
  // a stalled enable freezes the stream mid-word rather than dropping it
  assign advance   = videoEn && (!curValid_q || (beat_q == lastBeat));
  assign fReady    = advance && (state_q == SEQ_IDLE);
  assign popPix    = fReady && fValid && !fData[10];
  assign popCtl    = fReady && fValid && fData[10]; // [R11]
  assign codeIsEol = (code_q == `SVOF_CODE_EOL);
  assign codeIsSof = code_q[2] && !code_q[0] && !code_q[1] ? 1'b1
                   : (code_q[2] && code_q[1] && !code_q[0]);
  assign newIsEol  = (fData[2:0] == `SVOF_CODE_EOL);
  assign newIsSof  = fData[2] && !fData[0];

  svof_code_enc u_enc (
    .lineCode  (code_q),
    .lineNum   (lineCnt_q),
    .cmdByte   (cmdByte),
    .numHiByte (numHiByte),
    .numLoByte (numLoByte)
  );

  // ****************************************
  // pixel clipping
  // ****************************************
  logic [9:0] pixWord;
  logic [7:0] pix8;

  always_comb
  begin
    pix8 = fData[9:2]; // [R9]
    if (mode10)
    begin
      if (code_q == `SVOF_CODE_BK)
        pixWord = `SVOF_BLACK10; // [R3]
      else if (fData[9:0] == 10'h000)
        pixWord = `SVOF_PIX_MIN10; // [R2]
      else if (fData[9:0] == 10'h3ff)
        pixWord = `SVOF_PIX_MAX10; // [R2]
      else
        pixWord = fData[9:0];
    end
    else
    begin
      if (code_q == `SVOF_CODE_BK)
        pix8 = `SVOF_BLACK8; // [R3]
      else if (pix8 == 8'h00)
        pix8 = `SVOF_PIX_MIN8; // [R2]
      else if (pix8 == 8'hff)
        pix8 = `SVOF_PIX_MAX8; // [R2]
      pixWord = {pix8, 2'b00};
    end
  end

  // ****************************************
  // line average over the middle pixels
  // ****************************************
  logic [9:0]  pixIdx_q;
  logic [17:0] sum_q;
  logic [10:0] winLen;
  logic [10:0] winStart;
  logic        inWin;
  logic [9:0]  avg10;

  assign winLen   = quarterFmt ? `SVOF_AVG_QTR : `SVOF_AVG_FULL; // [R22]
  // short lines fall back to a window starting at pixel zero
  assign winStart = ({1'b0, lineWidth} > winLen)
                  ? 11'(({1'b0, lineWidth} - winLen) >> 1) : 11'h000;
  assign inWin    = ({1'b0, pixIdx_q} >= winStart)
                 && ({1'b0, pixIdx_q} < 11'(winStart + winLen));
  assign avg10    = quarterFmt ? sum_q[16:7] : sum_q[17:8];

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pixIdx_q <= '0;
      sum_q    <= '0;
    end
    else if (popCtl && !newIsEol)
    begin
      pixIdx_q <= '0;
      sum_q    <= '0;
    end
    else if (popPix)
    begin
      pixIdx_q <= pixIdx_q + 1'b1;
      if (inWin)
        sum_q <= sum_q + 18'(fData[9:0]);
    end
  end

  // ****************************************
  // line code and line counter
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      code_q    <= `SVOF_CODE_EOL;
      lineCnt_q <= '0;
    end
    else if (popCtl)
    begin
      code_q <= fData[2:0]; // [R12]
      if (newIsSof)
        lineCnt_q <= '0; // [R24]
      else if (!newIsEol)
        lineCnt_q <= lineCnt_q + 1'b1; // [R24]
    end
  end

  // ****************************************
  // next word selection
  // ****************************************
  always_comb
  begin
    state_d   = state_q;
    nextWord  = '0;
    nextValid = 1'b1;
    unique case (state_q)
      SEQ_IDLE:
      begin
        if (!fValid)
          nextValid = 1'b0;
        else if (fData[10])
        begin
          nextWord = ESC10; // [R18]
          state_d  = SEQ_ESC_B;
        end
        else
          nextWord = pixWord;
      end
      SEQ_ESC_B:
      begin
        nextWord = ESC10; // [R18]
        state_d  = SEQ_SYNC;
      end
      SEQ_SYNC:
      begin
        nextWord = SYNC10; // [R18]
        state_d  = SEQ_CMD;
      end
      SEQ_CMD:
      begin
        nextWord = {cmdByte, 2'b00}; // [R19] [R5]
        state_d  = SEQ_SUP_HI;
      end
      SEQ_SUP_HI:
      begin
        nextWord = codeIsEol ? {avg10[9:2], 2'b00} // [R22] [R9]
                             : {numHiByte, 2'b00}; // [R21]
        state_d  = SEQ_SUP_LO;
      end
      SEQ_SUP_LO:
      begin
        nextWord = codeIsEol ? {`SVOF_EOL_TAIL, 2'b00} // [R22]
                             : {numLoByte, 2'b00}; // [R21]
        state_d  = SEQ_IDLE; // [R13]
      end
      default:
      begin
        nextValid = 1'b0;
        state_d   = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q    <= SEQ_IDLE;
      curWord_q  <= '0;
      curValid_q <= 1'b0;
      curIsPix_q <= 1'b0;
      curIsCmd_q <= 1'b0;
      beat_q     <= 1'b0;
    end
    else if (advance)
    begin
      state_q    <= state_d;
      curWord_q  <= nextWord;
      curValid_q <= nextValid;
      curIsPix_q <= popPix;
      curIsCmd_q <= (state_q == SEQ_CMD);
      beat_q     <= 1'b0;
    end
    else if (videoEn && curValid_q)
      beat_q <= 1'b1;
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      videoDataOe <= 1'b0;
    else
      videoDataOe <= videoEn; // [R23]
  end

  // idle slots put zero on the wires; a lone zero cannot fake a sequence
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      videoDataOut     <= '0;
      fieldStartStrobe <= 1'b0;
      lineStartStrobe  <= 1'b0;
    end
    else
    begin
      fieldStartStrobe <= curIsCmd_q && codeIsSof;
      lineStartStrobe  <= curIsCmd_q && !codeIsEol;
      if (!curValid_q)
        videoDataOut <= '0;
      else
      begin
        unique case (outMode)
          SVOF_W5:
            videoDataOut <= {1'b0, beat_q ? curWord_q[4:0] : curWord_q[9:5]}; // [R4] [R10]
          SVOF_W4:
            videoDataOut <= {2'b00, beat_q ? curWord_q[5:2] : curWord_q[9:6]}; // [R8] [R10]
          default:
          begin
            videoDataOut     <= curWord_q[7:2]; // [R6] [R1]
            fieldStartStrobe <= curWord_q[9]; // [R7]
            lineStartStrobe  <= curWord_q[8]; // [R7]
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [9:0] hist1_q;
  logic [9:0] hist2_q;
  logic [9:0] hist3_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hist1_q <= '0;
      hist2_q <= '0;
      hist3_q <= '0;
    end
    else if (advance && curValid_q)
    begin
      hist1_q <= curWord_q;
      hist2_q <= hist1_q;
      hist3_q <= hist2_q;
    end
  end

  AST_OE_FOLLOWS_EN: assert property ( // [R23]
    videoEn != videoDataOe |=> videoDataOe == $past(videoEn))
    else $error("bus enable does not follow video enable");

  AST_CLIP10: assert property ( // [R2]
    curIsPix_q && mode10 |-> curWord_q >= `SVOF_PIX_MIN10 && curWord_q <= `SVOF_PIX_MAX10)
    else $error("10-bit pixel outside clip range");

  AST_CLIP8: assert property ( // [R2]
    curIsPix_q && !mode10 |-> curWord_q[9:2] inside {[`SVOF_PIX_MIN8:`SVOF_PIX_MAX8]}
                              && curWord_q[1:0] == 2'b00)
    else $error("8-bit pixel outside clip range");

  AST_CMD_PREFIX: assert property ( // [R18]
    $rose(curIsCmd_q) |-> hist1_q == SYNC10 && hist2_q == ESC10 && hist3_q == ESC10)
    else $error("command not preceded by escape and sync");

  AST_CMD_CODED: assert property ( // [R20]
    curIsCmd_q |-> curWord_q[9] && curWord_q[1:0] == 2'b00
                   && curWord_q[2] == ^curWord_q[8:6]
                   && curWord_q[5] == (curWord_q[7] ^ curWord_q[6]))
    else $error("command byte coding wrong");

  AST_TAIL_LEN: assert property ( // [R13]
    curIsCmd_q && advance |=> curValid_q && state_q == SEQ_SUP_LO)
    else $error("control sequence tail too short");

  AST_SEQ_END: assert property ( // [R13]
    state_q == SEQ_SUP_LO && advance |=> curValid_q && state_q == SEQ_IDLE)
    else $error("control sequence does not end after its sixth word");

  AST_LINE_NUM: assert property ( // [R21]
    curIsCmd_q && advance && !codeIsEol |=> !curWord_q[9] && ^curWord_q[9:2])
    else $error("line number half badly formed");

  AST_EOL_TAIL: assert property ( // [R22]
    state_q == SEQ_SUP_LO && advance && codeIsEol |=> curWord_q == {`SVOF_EOL_TAIL, 2'b00})
    else $error("end-of-line tail not all ones");

  AST_LINE_STEP: assert property ( // [R24]
    popCtl && !newIsEol && !newIsSof |=> lineCnt_q == $past(lineCnt_q) + 12'h001)
    else $error("line counter did not step");

  AST_FIELD_RESTART: assert property ( // [R24]
    popCtl && newIsSof |=> lineCnt_q == 12'h000 ##1 lineCnt_q == 12'h000)
    else $error("line counter did not restart");

  AST_W4_LOW_WIRES: assert property ( // [R10]
    outMode == SVOF_W4 && curValid_q |=> videoDataOut[5:4] == 2'b00)
    else $error("4-wire mode drove upper wires");

  COV_SEQUENCE: cover property (popCtl ##[1:20] state_q == SEQ_IDLE);
  COV_EOL_5W: cover property (mode10 && popCtl && newIsEol);
  COV_FULL: cover property (!inReady && inValid);
  COV_W8_SOF: cover property (outMode == SVOF_W8 && popCtl && newIsSof);

endmodule : svof_formatter

// file: core/svof_params.svh
`ifndef SVOF_PARAMS_SVH
`define SVOF_PARAMS_SVH

// ****************************************
// pixel clip limits and black levels
// ****************************************
`define SVOF_PIX_MIN10 10'h001
`define SVOF_PIX_MAX10 10'h3fe
`define SVOF_PIX_MIN8 8'h01
`define SVOF_PIX_MAX8 8'hfe
`define SVOF_BLACK10 10'h040
`define SVOF_BLACK8 8'h10

// ****************************************
// embedded sequence bytes and line codes
// ****************************************
`define SVOF_ESC_BYTE 8'hff
`define SVOF_SYNC_BYTE 8'h00
`define SVOF_EOL_TAIL 8'hff
`define SVOF_CODE_EOL 3'h0
`define SVOF_CODE_BK 3'h2

// ****************************************
// line average windows and buffering
// ****************************************
`define SVOF_AVG_FULL 11'h100
`define SVOF_AVG_QTR 11'h080
`define SVOF_FIFO_WIDTH 11
`define SVOF_FIFO_DEPTH 32

`endif

// file: core/svof_pkg.sv
package svof_pkg;

  typedef enum logic [1:0]
  {
    SVOF_W4,
    SVOF_W5,
    SVOF_W8
  } svof_mode_t;

  typedef enum logic [2:0]
  {
    SEQ_IDLE,
    SEQ_ESC_B,
    SEQ_SYNC,
    SEQ_CMD,
    SEQ_SUP_HI,
    SEQ_SUP_LO
  } svof_seq_t;

endpackage : svof_pkg

// file: core/svof_fifo.sv
`timescale 1ns/100ps
`include "svof_params.svh"

module svof_fifo
  import svof_pkg::*;
#(
  parameter int WIDTH = `SVOF_FIFO_WIDTH,
  parameter int DEPTH = `SVOF_FIFO_DEPTH
)
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= inData;
  end

  // ready is registered so it can leave the top straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_d;
      inReady <= (count_d != (AW+1)'(DEPTH));
    end
  end

endmodule : svof_fifo

// file: core/svof_code_enc.sv
`timescale 1ns/100ps

module svof_code_enc
  import svof_pkg::*;
(
  input  wire logic [2:0]  lineCode,
  input  wire logic [11:0] lineNum,
  output logic      [7:0]  cmdByte,
  output logic      [7:0]  numHiByte,
  output logic      [7:0]  numLoByte
);

  // top bit fixed high keeps the command byte away from zero
  assign cmdByte = {1'b1, lineCode,
                    lineCode[1] ^ lineCode[0],
                    lineCode[2] ^ lineCode[0],
                    lineCode[2] ^ lineCode[1],
                    ^lineCode}; // [R14] [R20]

  assign numHiByte = {1'b0, lineNum[11:6], ~^lineNum[11:6]}; // [R21]
  assign numLoByte = {1'b0, lineNum[5:0], ~^lineNum[5:0]}; // [R21]

endmodule : svof_code_enc

// file: testbench/svof_host_model.sv
`timescale 1ns/100ps

// ****************************************
// host receiver: word assembly and sync loss
// ****************************************
module svof_host_model
  import svof_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire svof_mode_t outMode,
  input  wire logic [5:0] videoDataOut,
  input  wire logic       videoDataOe,
  input  wire logic       fieldStartStrobe,
  input  wire logic       lineStartStrobe,
  output logic            wordValid,
  output logic      [9:0] wordData,
  output logic            lossOfSync,
  output int              strobeErrs
);
  logic [9:0] acc;
  logic [9:0] w;
  logic [7:0] n, v, h1, h2, h3, s1;
  logic [3:0] syn;
  logic [2:0] code;
  bit         beat, algn, pend, lost, eolSeen, fldOn;
  int         pos, prevNum, num;

  always @(posedge core_clk)
  begin
    wordValid <= 1'b0;
    if (rst)
    begin
      beat = 0;
      algn = 0;
      pos = 0;
      lost = 0;
      eolSeen = 0;
      fldOn = 0;
      h1 = '0;
      lossOfSync <= 1'b0;
      strobeErrs <= 0;
    end
    else if (videoDataOe)
    begin
      n = outMode == SVOF_W8 ? {fieldStartStrobe, lineStartStrobe, videoDataOut}
        : outMode == SVOF_W5 ? {3'h0, videoDataOut[4:0]} : {4'h0, videoDataOut[3:0]};
      pend = h3 == 8'hff && h2 == 8'hff && h1 == 8'h00;
      if (pend && !beat)
        code = outMode == SVOF_W5 ? n[3:1] : n[2:0];
      if (outMode != SVOF_W8 && (fieldStartStrobe !== (pend && (code == 4 || code == 6))
          || lineStartStrobe !== (pend && code != 0)))
        strobeErrs <= strobeErrs + 1;
      // idle zeros only skipped between bursts, a zero beat inside a word is data
      if (algn || n != 0)
      begin
        if (outMode == SVOF_W8 || beat)
        begin
          w = outMode == SVOF_W8 ? {2'h0, n} : outMode == SVOF_W5 ? {acc[4:0], n[4:0]}
            : {2'h0, acc[3:0], n[3:0]};
          v = outMode == SVOF_W5 ? w[9:2] : w[7:0];
          beat = 0;
          algn = 1;
          wordValid <= !lost;
          wordData <= w;
          if (pend)
          begin
            syn = {v[5] ^ v[4] ^ v[3], v[6] ^ v[4] ^ v[2], v[6] ^ v[5] ^ v[1], ^{v[6:4], v[0]}};
            code = v[6:4] ^ {syn == 4'h7, syn == 4'hb, syn == 4'hd};
            if (!v[7] || !(syn inside {0, 1, 2, 4, 8, 7, 11, 13}))
              lost = 1;
            if (code == 0 && eolSeen)
              lost = 1;
            eolSeen = code == 0;
            if ((code == 5 || code == 7) && !fldOn)
              lost = 1;
            if (code == 4 || code == 6)
            begin
              fldOn = 1;
              lost = 0;
            end
            pos = 1;
          end
          else if (pos == 1)
          begin
            s1 = v;
            pos = 2;
          end
          else if (pos == 2)
          begin
            pos = 0;
            num = {s1[6:1], v[6:1]};
            if (code == 0)
              algn = 0;
            else if (code inside {1, 2, 3} && num != prevNum + 1)
              lost = 1;
            if (code != 0)
              prevNum = num;
          end
          h3 = h2;
          h2 = h1;
          h1 = v;
        end
        else
        begin
          acc = {2'h0, n};
          beat = 1;
        end
      end
      if (lost)
        lossOfSync <= 1'b1;
    end
  end
endmodule : svof_host_model

// file: testbench/tb.sv
`timescale 1ns/100ps

// ****************************************
// stimulus, reference model and scoreboard
// ****************************************
module tb
  import svof_pkg::*;
;
  logic       core_clk = 0, rst = 1, videoEn = 0, quarterFmt = 0;
  logic       inValid = 0, inIsCtl = 0;
  svof_mode_t outMode = SVOF_W5;
  logic [9:0] lineWidth = '0, inData = '0, wordData;
  logic [5:0] videoDataIn = '0, videoDataOut;
  logic       inReady, videoDataOe, fss, lss, wordValid, lossOfSync;
  int         strobeErrs, n_errors = 0, checks = 0, cyc = 0, lineCnt = 0, e;
  int         expQ[$];
  svof_mode_t modes[3] = '{SVOF_W5, SVOF_W4, SVOF_W8};
  int         codes[8] = '{4, 2, 1, 3, 5, 6, 3, 7};

  always #5 core_clk = ~core_clk;

  svof_formatter dut (.core_clk(core_clk), .rst(rst), .videoEn(videoEn), .outMode(outMode),
    .quarterFmt(quarterFmt), .lineWidth(lineWidth), .inValid(inValid), .inIsCtl(inIsCtl),
    .inData(inData), .inReady(inReady), .videoDataIn(videoDataIn),
    .videoDataOut(videoDataOut), .videoDataOe(videoDataOe), .fieldStartStrobe(fss),
    .lineStartStrobe(lss));

  svof_host_model host (.core_clk(core_clk), .rst(rst), .outMode(outMode),
    .videoDataOut(videoDataOut), .videoDataOe(videoDataOe), .fieldStartStrobe(fss),
    .lineStartStrobe(lss), .wordValid(wordValid), .wordData(wordData),
    .lossOfSync(lossOfSync), .strobeErrs(strobeErrs));

  task results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task check(string what, logic [9:0] exp, logic [9:0] seen);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function int wd(int b);
    return outMode == SVOF_W5 ? b << 2 : b;
  endfunction : wd

  function int cmdb(int c);
    return {1'b1, c[2:0], c[1] ^ c[0], c[2] ^ c[0], c[2] ^ c[1], ^c[2:0]};
  endfunction : cmdb

  function int nb(int n);
    return {1'b0, n[5:0], ~^n[5:0]};
  endfunction : nb

  task push_ctl(int c, int s1, int s2);
    expQ.push_back(wd(8'hff));
    expQ.push_back(wd(8'hff));
    expQ.push_back(wd(8'h00));
    expQ.push_back(wd(cmdb(c)));
    expQ.push_back(s1);
    expQ.push_back(s2);
  endtask : push_ctl

  task send(bit c, int d);
    inValid <= 1'b1;
    inIsCtl <= c;
    inData <= d[9:0];
    for (int i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (inReady === 1'b1)
        break;
    end
    #1;
  endtask : send

  // whole line loaded while stopped, so the bus never idles inside a line
  task do_line(int code, int np, bit hold);
    int sum, raw, lw, ws, wl;
    sum = 0;
    wl = quarterFmt ? 128 : 256;
    // visible lines claim a long width so the window sits off pixel zero
    lw = code == 3 ? np + wl + 20 : np;
    ws = lw > wl ? (lw - wl) / 2 : 0;
    lineWidth <= lw[9:0];
    lineCnt = (code == 4 || code == 6) ? 0 : lineCnt + 1;
    send(1, code);
    push_ctl(code, wd(nb(lineCnt >> 6)), wd(nb(lineCnt)));
    for (int p = 0; p < np; p++)
    begin
      raw = p == 0 ? 0 : p == 1 ? 1023 : $urandom_range(1023, 0);
      if (p >= ws && p < ws + wl)
        sum += raw;
      send(0, raw);
      if (code == 2)
        expQ.push_back(wd(16));
      else if (outMode == SVOF_W5)
        expQ.push_back(raw < 1 ? 1 : raw > 1022 ? 1022 : raw);
      else
        expQ.push_back((raw >> 2) < 1 ? 1 : (raw >> 2) > 254 ? 254 : raw >> 2);
    end
    send(1, 0);
    push_ctl(0, code == 2 ? -1 : wd((sum >> (quarterFmt ? 7 : 8)) >> 2), wd(8'hff));
    inValid <= 1'b0;
    if (np == 30)
      check("fifo full", 0, inReady);
    videoEn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("oe on", 1, videoDataOe);
    if (hold)
    begin
      videoEn <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("oe off", 0, videoDataOe);
      repeat (3) @(posedge core_clk);
      #1;
      videoEn <= 1'b1;
    end
    for (int i = 0; i < 2000 && expQ.size() != 0; i++)
      @(posedge core_clk);
    check("words left", 0, expQ.size() != 0);
    repeat (4) @(posedge core_clk);
    #1;
    videoEn <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : do_line

  always @(posedge core_clk)
  begin
    if (wordValid === 1'b1)
    begin
      e = expQ.size() != 0 ? expQ.pop_front() : 10'h3ff;
      if (e >= 0)
        check("word", e[9:0], wordData);
    end
    if (videoDataOe === 1'b1 && outMode != SVOF_W8)
      check("high wires", 0, outMode == SVOF_W5 ? {1'b0, videoDataOut[5]}
        : videoDataOut[5:4]);
  end

  // a stalled handshake ends the run here
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    void'($urandom(91805));
    repeat (5) @(posedge core_clk);
    #1;
    rst = 0;
    @(posedge core_clk);
    #1;
    for (int m = 0; m < 3; m++)
    begin
      outMode = modes[m];
      quarterFmt = m[0];
      for (int i = 0; i < 8; i++)
        do_line(codes[i], i == 0 ? 30 : $urandom_range(30, 2), i == 2);
      $display("test mode %0d done", m);
    end
    check("sync kept", 0, lossOfSync);
    check("strobes", 0, strobeErrs != 0);
    results();
  end
endmodule : tb
